// >>> bench/core_model.sv
// Processor core stand-in: program counter and eight-deep return stack.
// Assumes the bench pulses sleep_req_i and return_from_irq_instr_req_i for one cycle.
// The program counter holds the sleep address while asleep.
`timescale 1ns/1ps
module core_model
  import irq_reset_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic sleep_req_i,
  input wire logic return_from_irq_instr_req_i,
  input wire logic pc_load_i,
  input wire logic [12:0] pc_value_i,
  input wire logic stack_push_i,
  input wire logic [12:0] stack_data_i,
  output core_ctl_s core_ctl_o,
  output logic [12:0] pc_o
);
  logic [12:0] stack_r [8];
  logic [2:0] sp_r;
  logic tick_r;

  always_ff @(posedge core_clk_i) begin
    tick_r <= rst_i ? 1'b0 : !tick_r;
    core_ctl_o <= '{sleep_req_i, return_from_irq_instr_req_i, tick_r};
    if (rst_i) begin
      pc_o <= 13'h0000;
      sp_r <= 3'h0;
    end else if (pc_load_i) begin
      pc_o <= pc_value_i;
    end else if (return_from_irq_instr_req_i) begin
      pc_o <= stack_r[sp_r - 3'h1];
      sp_r <= sp_r - 3'h1;
    end
    if (!rst_i && stack_push_i) begin
      stack_r[sp_r] <= stack_data_i;
      sp_r <= sp_r + 3'h1;
    end
  end
endmodule

// >>> bench/tb_top.sv
// Self-checking bench for the reset-state and interrupt vectoring block.
// Assumes core_model stands in for the core and owns pc_i and core_ctl_i.
`timescale 1ns/1ps
module tb_top;
  import irq_reset_pkg::*;
  typedef struct packed {logic [12:0] pc; logic push; logic [12:0] ret;}
    load_s;
  typedef struct packed {logic [7:0] val; logic [7:0] mask;} read_s;

  logic core_clk_i, rst_i, watchdog_wake_i, pin_i, rising_i;
  logic reg_we_i, reg_re_i, sleep_req, return_from_irq_instr_req;
  reset_kind_e reset_kind_i;
  core_ctl_s core_ctl;
  logic [12:0] pc, pc_value_o, stack_data_o;
  irq_events_s events_i;
  logic [3:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, r1, r2;
  logic pc_load_o, stack_push_o, sleeping_o;
  logic [5:0] port_a_direction_o;
  load_s load_q[$];
  read_s read_q[$];
  load_s ln;
  read_s rn;
  int n_mismatch = 0;
  int compares = 0;
  bit mon_en = 0;
  bit rd_due = 0;
  reset_kind_e kinds[5] = '{RST_POWER_ON, RST_BROWNOUT, RST_WATCHDOG,
    RST_PIN_RUN, RST_PIN_SLEEP};
  logic [7:0] st_exp[5] = '{8'h18, 8'h1D, 8'h0D, 8'h0D, 8'h15};

  irq_reset_ctrl u_irq_reset_ctrl (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .reset_kind_i(reset_kind_i),
    .watchdog_wake_i(watchdog_wake_i), .core_ctl_i(core_ctl), .pc_i(pc),
    .events_i(events_i), .ext_edge_irq_pin_i(pin_i),
    .ext_edge_rising_i(rising_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o), .pc_load_o(pc_load_o),
    .pc_value_o(pc_value_o), .stack_push_o(stack_push_o),
    .stack_data_o(stack_data_o), .sleeping_o(sleeping_o),
    .port_a_direction_o(port_a_direction_o));

  core_model u_core_model (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .sleep_req_i(sleep_req),
    .return_from_irq_instr_req_i(return_from_irq_instr_req), .pc_load_i(pc_load_o),
    .pc_value_i(pc_value_o), .stack_push_i(stack_push_o),
    .stack_data_i(stack_data_o), .core_ctl_o(core_ctl), .pc_o(pc));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [12:0] seen, input logic [12:0] exp,
                       input string what);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask

  task automatic test_done();
    $display("mismatches %0d, compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge core_clk_i);
    reg_we_i <= 1'b0;
    @(posedge core_clk_i);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] v,
                    input logic [7:0] m);
    read_q.push_back('{v, m});
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge core_clk_i);
    reg_re_i <= 1'b0;
    @(posedge core_clk_i);
  endtask

  task automatic pulse(input irq_events_s e);
    events_i <= e;
    @(posedge core_clk_i);
    events_i <= '0;
    @(posedge core_clk_i);
  endtask

  task automatic core_req(input logic sl, input logic rf);
    sleep_req <= sl;
    return_from_irq_instr_req <= rf;
    @(posedge core_clk_i);
    sleep_req <= 1'b0;
    return_from_irq_instr_req <= 1'b0;
    @(posedge core_clk_i);
  endtask

  task automatic note(input logic [12:0] p, input logic u,
                      input logic [12:0] r);
    load_q.push_back('{p, u, r});
  endtask

  // Port B change pulse, then the edge count up to the vector load
  task automatic fire_timed();
    int n;
    n = 0;
    events_i <= '{1'b0, 1'b1, 8'h00, 8'h00};
    @(posedge core_clk_i);
    events_i <= '0;
    do begin
      @(negedge core_clk_i);
      n++;
    end while (pc_load_o !== 1'b1 && n < 20);
    check(13'((n - 1) inside {3, 4}), 13'h0001, "latency");
    @(posedge core_clk_i);
  endtask

  // ****************************************************************
  // Result monitor
  // ****************************************************************
  always @(negedge core_clk_i) begin
    if (rd_due) begin
      rn = read_q.pop_front();
      check(13'(reg_rdata_o & rn.mask), 13'(rn.val), "read data");
    end
    rd_due = reg_re_i;
    if (mon_en && pc_load_o === 1'b1) begin
      if (load_q.size() == 0) begin
        check(13'h0001, 13'h0000, "unexpected pc load");
      end else begin
        ln = load_q.pop_front();
        check(pc_value_o, ln.pc, "pc value");
        check(13'(stack_push_o), 13'(ln.push), "push");
        if (ln.push) begin
          check(stack_data_o, ln.ret, "return address");
        end
      end
    end
  end

  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = !core_clk_i;
  end

  initial begin
    repeat (5000) @(posedge core_clk_i);
    n_mismatch++;
    $display("watchdog expired");
    test_done();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst_i = 1'b1;
    reset_kind_i = RST_NONE;
    watchdog_wake_i = 1'b0;
    pin_i = 1'b0;
    rising_i = 1'b1;
    events_i = '0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 8'h00;
    reg_we_i = 1'b0;
    reg_re_i = 1'b0;
    sleep_req = 1'b0;
    return_from_irq_instr_req = 1'b0;
    void'($urandom(32'h8E39));
    repeat (10) @(negedge core_clk_i);
    check(13'(pc_load_o), 13'h0001, "load in reset");
    check(pc_value_o, 13'h0000, "reset vector");
    @(posedge core_clk_i);
    rst_i <= 1'b0;
    tick(3);
    mon_en = 1;
    check(13'(port_a_direction_o), 13'h003F, "direction");
    rd(4'h3, 8'h18, 8'hFF);
    rd(4'hB, 8'h00, 8'hFF);
    rd(4'h5, 8'h3F, 8'hFF);
    rd(4'hF, 8'h00, 8'hFF);
    rd(4'hE, 8'h00, 8'hFF);
    $display("test reset values done");

    r1 = 8'($urandom());
    r2 = 8'($urandom());
    pulse('{1'b1, 1'b1, r1, r2});
    rd(4'hB, 8'h05, 8'hFF);
    rd(4'hC, r1 & 8'h3F, 8'hFF);
    rd(4'hD, r2 & 8'h0F, 8'hFF);
    for (int p = 0; p < 2; p++) begin
      rising_i <= p[0];
      pin_i <= !p[0];
      tick(6);
      wr(4'hB, 8'h00);
      pin_i <= p[0];
      tick(8);
      rd(4'hB, 8'h02, 8'h03);
    end
    wr(4'hC, 8'h00);
    rd(4'hC, 8'h00, 8'hFF);
    reg_addr_i <= 4'hB;
    reg_wdata_i <= 8'h00;
    reg_we_i <= 1'b1;
    events_i <= '{1'b1, 1'b0, 8'h00, 8'h00};
    @(posedge core_clk_i);
    reg_we_i <= 1'b0;
    events_i <= '0;
    @(posedge core_clk_i);
    rd(4'hB, 8'h04, 8'hFF);
    $display("test flags done");

    wr(4'hB, 8'h08);
    pulse('{1'b0, 1'b1, 8'h00, 8'h00});
    tick(8);
    note(13'h0004, 1'b1, 13'h0000);
    wr(4'hB, 8'h89);
    tick(8);
    rd(4'hB, 8'h09, 8'hFF);
    wr(4'hB, 8'h08);
    core_req(1'b0, 1'b1);
    tick(3);
    rd(4'hB, 8'h88, 8'hFF);
    note(13'h0004, 1'b1, 13'h0000);
    fire_timed();
    tick(4);
    wr(4'hB, 8'h00);
    wr(4'h8, 8'h01);
    wr(4'hB, 8'h80);
    pulse('{1'b0, 1'b0, 8'h01, 8'h00});
    tick(8);
    note(13'h0004, 1'b1, 13'h0004);
    wr(4'hB, 8'hC0);
    tick(8);
    rd(4'hB, 8'h40, 8'hFF);
    wr(4'hC, 8'h00);
    $display("test vectoring done");

    wr(4'hB, 8'h08);
    core_req(1'b1, 1'b0);
    @(negedge core_clk_i);
    check(13'(sleeping_o), 13'h0001, "asleep");
    @(posedge core_clk_i);
    note(13'h0005, 1'b0, 13'h0000);
    pulse('{1'b0, 1'b1, 8'h00, 8'h00});
    tick(6);
    rd(4'h3, 8'h10, 8'hF8);
    rd(4'hB, 8'h09, 8'hFF);
    wr(4'hB, 8'h88);
    core_req(1'b1, 1'b0);
    note(13'h0006, 1'b0, 13'h0000);
    note(13'h0004, 1'b1, 13'h0006);
    pulse('{1'b0, 1'b1, 8'h00, 8'h00});
    tick(8);
    rd(4'h3, 8'h10, 8'hF8);
    wr(4'hB, 8'h00);
    core_req(1'b1, 1'b0);
    note(13'h0005, 1'b0, 13'h0000);
    watchdog_wake_i <= 1'b1;
    @(posedge core_clk_i);
    watchdog_wake_i <= 1'b0;
    tick(6);
    rd(4'h3, 8'h00, 8'hF8);
    $display("test wake-up done");

    for (int k = 0; k < 5; k++) begin
      wr(4'h3, 8'h05);
      wr(4'h5, 8'h00);
      wr(4'hB, 8'h80);
      if (kinds[k] == RST_PIN_SLEEP) begin
        core_req(1'b1, 1'b0);
      end
      note(13'h0000, 1'b0, 13'h0000);
      reset_kind_i <= kinds[k];
      @(posedge core_clk_i);
      reset_kind_i <= RST_NONE;
      tick(4);
      check(13'(port_a_direction_o), 13'h003F, "direction");
      rd(4'h3, st_exp[k], (k == 0) ? 8'hF8 : 8'hFF);
      rd(4'hB, 8'h00, 8'h80);
    end
    $display("test device resets done");
    tick(4);
    test_done();
  end
endmodule

// >>> logic/edge_sync.sv
// Two-stage synchroniser with a rising or falling edge detector.
// Assumes the input is asynchronous to core_clk_i.
`timescale 1ns/1ps
module edge_sync (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  input wire logic rising_i,
  output logic edge_o
);

  logic meta_r;
  logic sync_r;
  logic last_r;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign edge_o = rising_i ? (sync_r & ~last_r) : (~sync_r & last_r);

endmodule

// >>> logic/irq_reset_ctrl.sv
// Reset-state loader and interrupt flag, enable and vectoring logic.
// Assumes the core pulses instr_done once per instruction cycle, and
// that reset_kind_i is a synchronous one-cycle tag from the reset unit.
//
// Contract
// - Every reset kind loads the program counter with zero.
// - Pin reset during sleep sets status top nibble 0001, bit3 0.
// - Interrupt wake resumes at next address, timeout set, powerdown clear.
// - Interrupt wake with global enable set goes to the interrupt vector.
// - Unimplemented special register bits read as zero.
// - Any enabled flag in control, or in either peripheral flags register with control bit 6 set, causes an interrupt wake-up.
// - Every reset sets port A direction to all ones (inputs).
// - Flags set on their event regardless of any enable.
// - Global enable at control bit 7 gates every request except wake-up from sleep.
// - Global enable plus flagged enabled source takes the interrupt after two wait cycles and a vector cycle.
// - Every reset clears the global enable.
// - Return from interrupt sets the global enable again.
// - Edge pin, port B change, timer zero flags live in control.
// - Peripheral flags and enables in two registers, gated by group enable.
// - Taking an interrupt clears enable, pushes return, loads vector.
// - External event to vector takes three to four core cycles.
// - Latency is the same for one or two cycle instructions.
// - Power-on leaves both timeout and powerdown flags at one.
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "irq_reset_map.svh"
module irq_reset_ctrl
  import irq_reset_pkg::*;
#(
  parameter int PC_W = 13,
  parameter int LATENCY = `EXT_LATENCY_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire reset_kind_e reset_kind_i,
  input wire logic watchdog_wake_i,
  input wire core_ctl_s core_ctl_i,
  input wire logic [PC_W-1:0] pc_i,
  input wire irq_events_s events_i,
  input wire logic ext_edge_irq_pin_i,
  input wire logic ext_edge_rising_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o,
  output logic pc_load_o,
  output logic [PC_W-1:0] pc_value_o,
  output logic stack_push_o,
  output logic [PC_W-1:0] stack_data_o,
  output logic sleeping_o,
  output logic [5:0] port_a_direction_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    seq_state_e seq;
    logic [1:0] wait_cnt;
    logic [7:0] irq_control_register;
    logic [7:0] periph_flags_first;
    logic [7:0] periph_flags_second;
    logic [7:0] periph_enables_first;
    logic [7:0] periph_enables_second;
    logic [7:0] status;
    logic [1:0] power_control_status;
    logic [5:0] port_a_direction;
    logic [7:0] rdata;
    logic pc_load;
    logic [PC_W-1:0] pc_value;
    logic push;
    logic [PC_W-1:0] push_data;
    logic sleeping;
  } state_s;

  state_s st_r;
  state_s st_nxt;
  logic ext_edge;
  logic pending;
  logic periph_any;
  logic [7:0] ic_set;
  logic [7:0] pf1_set;
  logic [7:0] pf2_set;

  edge_sync u_edge_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .pin_i(ext_edge_irq_pin_i),
    .rising_i(ext_edge_rising_i),
    .edge_o(ext_edge)
  );

  // ****************************************************************
  // Request evaluation
  // ****************************************************************
  assign ic_set = {5'h00, events_i.timer_zero_ovf, ext_edge,
                   events_i.port_b_change};
  assign pf1_set = events_i.periph_first & `PERIPH_FIRST_MASK;
  assign pf2_set = events_i.periph_second & `PERIPH_SECOND_MASK;
  assign periph_any = st_r.irq_control_register[`IC_PEIE] &
    (|(st_r.periph_flags_first & st_r.periph_enables_first) |
     |(st_r.periph_flags_second & st_r.periph_enables_second));
  assign pending = periph_any |
    (st_r.irq_control_register[`IC_T0IE] &
     st_r.irq_control_register[`IC_T0IF]) |
    (st_r.irq_control_register[`IC_EXTIE] &
     st_r.irq_control_register[`IC_EXTIF]) |
    (st_r.irq_control_register[`IC_RBIE] &
     st_r.irq_control_register[`IC_RBIF]);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.pc_load = 1'b0;
    st_nxt.push = 1'b0;
    st_nxt.rdata = 8'h00;
    // Register writes; writing zero to a flag clears it
    if (reg_we_i) begin
      if (reg_addr_i == `OFS_IRQ_CONTROL) begin
        st_nxt.irq_control_register = reg_wdata_i;
      end else if (reg_addr_i == `OFS_PERIPH_FLAGS_FIRST) begin
        st_nxt.periph_flags_first = reg_wdata_i & `PERIPH_FIRST_MASK;
      end else if (reg_addr_i == `OFS_PERIPH_FLAGS_SECOND) begin
        st_nxt.periph_flags_second = reg_wdata_i & `PERIPH_SECOND_MASK;
      end else if (reg_addr_i == `OFS_PERIPH_EN_FIRST) begin
        st_nxt.periph_enables_first = reg_wdata_i & `PERIPH_FIRST_MASK;
      end else if (reg_addr_i == `OFS_PERIPH_EN_SECOND) begin
        st_nxt.periph_enables_second = reg_wdata_i & `PERIPH_SECOND_MASK;
      end else if (reg_addr_i == `OFS_PORT_A_DIRECTION) begin
        st_nxt.port_a_direction = reg_wdata_i[5:0];
      end else if (reg_addr_i == `OFS_POWER_CONTROL) begin
        st_nxt.power_control_status = reg_wdata_i[1:0];
      end else if (reg_addr_i == `OFS_STATUS) begin
        st_nxt.status[2:0] = reg_wdata_i[2:0];
      end
    end
    // Events set flags after any write, so set wins over clear
    st_nxt.irq_control_register = st_nxt.irq_control_register | ic_set;
    st_nxt.periph_flags_first = st_nxt.periph_flags_first | pf1_set;
    st_nxt.periph_flags_second = st_nxt.periph_flags_second | pf2_set;
    // Reads: unmapped offsets and unused bits return zero
    if (reg_re_i) begin
      if (reg_addr_i == `OFS_IRQ_CONTROL) begin
        st_nxt.rdata = st_r.irq_control_register;
      end else if (reg_addr_i == `OFS_PERIPH_FLAGS_FIRST) begin
        st_nxt.rdata = st_r.periph_flags_first & `PERIPH_FIRST_MASK;
      end else if (reg_addr_i == `OFS_PERIPH_FLAGS_SECOND) begin
        st_nxt.rdata = st_r.periph_flags_second & `PERIPH_SECOND_MASK;
      end else if (reg_addr_i == `OFS_PERIPH_EN_FIRST) begin
        st_nxt.rdata = st_r.periph_enables_first & `PERIPH_FIRST_MASK;
      end else if (reg_addr_i == `OFS_PERIPH_EN_SECOND) begin
        st_nxt.rdata = st_r.periph_enables_second & `PERIPH_SECOND_MASK;
      end else if (reg_addr_i == `OFS_PORT_A_DIRECTION) begin
        st_nxt.rdata = {2'b00, st_r.port_a_direction};
      end else if (reg_addr_i == `OFS_POWER_CONTROL) begin
        st_nxt.rdata = {6'h00, st_r.power_control_status};
      end else if (reg_addr_i == `OFS_STATUS) begin
        st_nxt.rdata = st_r.status;
      end
    end
    // Instruction sequencing
    case (st_r.seq)
      SEQ_RUN: begin
        if (core_ctl_i.return_from_irq_instr) begin
          st_nxt.irq_control_register[`IC_GIE] = 1'b1;
        end
        if (st_r.irq_control_register[`IC_GIE] & pending &
            ~core_ctl_i.return_from_irq_instr) begin
          st_nxt.seq = SEQ_WAIT;
          st_nxt.wait_cnt = 2'(LATENCY - 2);
        end else if (core_ctl_i.sleep) begin
          st_nxt.seq = SEQ_SLEEP;
          st_nxt.status[`ST_TO] = 1'b1;
          st_nxt.status[`ST_PD] = 1'b0;
        end
      end
      SEQ_SLEEP: begin
        if (watchdog_wake_i) begin
          st_nxt.seq = SEQ_RUN;
          st_nxt.status[`ST_TO] = 1'b0;
          st_nxt.status[`ST_PD] = 1'b0;
          st_nxt.pc_load = 1'b1;
          st_nxt.pc_value = PC_W'(pc_i + 1'b1);
        end else if (pending) begin
          st_nxt.status[`ST_TO] = 1'b1;
          st_nxt.status[`ST_PD] = 1'b0;
          st_nxt.pc_load = 1'b1;
          st_nxt.pc_value = PC_W'(pc_i + 1'b1);
          // The wake source flag set above is what asks for
          st_nxt.seq = st_r.irq_control_register[`IC_GIE] ?
                       SEQ_VECTOR : SEQ_RUN;
        end
      end
      SEQ_WAIT: begin
        // Counted in core cycles, not instructions, so two-cycle
        // instructions do not stretch the latency
        if (st_r.wait_cnt == 2'h0) begin
          st_nxt.seq = SEQ_VECTOR;
        end else begin
          st_nxt.wait_cnt = st_r.wait_cnt - 2'h1;
        end
      end
      SEQ_VECTOR: begin
        st_nxt.seq = SEQ_RUN;
        st_nxt.irq_control_register[`IC_GIE] = 1'b0;
        st_nxt.push = 1'b1;
        st_nxt.push_data = st_r.pc_load ? st_r.pc_value : pc_i;
        st_nxt.pc_load = 1'b1;
        st_nxt.pc_value = PC_W'(`IRQ_VECTOR);
      end
      default: begin
        st_nxt.seq = SEQ_RUN;
      end
    endcase
    // Resets of the device, highest priority
    if (reset_kind_i != RST_NONE) begin
      st_nxt.seq = SEQ_RUN;
      st_nxt.pc_load = 1'b1;
      st_nxt.pc_value = PC_W'(`RESET_VECTOR);
      st_nxt.push = 1'b0;
      st_nxt.irq_control_register = 8'h00;
      st_nxt.periph_flags_first = 8'h00;
      st_nxt.periph_flags_second = 8'h00;
      st_nxt.periph_enables_first = 8'h00;
      st_nxt.periph_enables_second = 8'h00;
      st_nxt.port_a_direction = `PORT_A_DIR_RESET;
      st_nxt.status[7:5] = 3'b000;
      case (reset_kind_i)
        RST_POWER_ON: begin
          st_nxt.status[4:3] = 2'b11;
          st_nxt.power_control_status[`PC_POR] = 1'b0;
        end
        RST_BROWNOUT: begin
          st_nxt.status[4:3] = 2'b11;
          st_nxt.power_control_status[`PC_BOR] = 1'b0;
        end
        RST_PIN_SLEEP: begin
          st_nxt.status[4:3] = 2'b10;
        end
        RST_WATCHDOG: begin
          st_nxt.status[4:3] = 2'b01;
        end
        default: begin
          st_nxt.status[4:3] = st_r.status[4:3];
        end
      endcase
    end
    // Registered so the sleep indication leaves a flip-flop directly
    st_nxt.sleeping = (st_nxt.seq == SEQ_SLEEP);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_r <= '0;
      st_r.pc_load <= 1'b1;
      st_r.status <= 8'h18;
      st_r.port_a_direction <= `PORT_A_DIR_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata_o = st_r.rdata;
  assign pc_load_o = st_r.pc_load;
  assign pc_value_o = st_r.pc_value;
  assign stack_push_o = st_r.push;
  assign stack_data_o = st_r.push_data;
  assign sleeping_o = st_r.sleeping;
  assign port_a_direction_o = st_r.port_a_direction;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_reset_pc_zero: assert property (@(posedge core_clk_i)
    disable iff (rst_i)
    (reset_kind_i != RST_NONE) |=> pc_load_o && pc_value_o == '0)
    else $error("reset did not load address zero");
  a_pin_sleep_status: assert property (@(posedge core_clk_i)
    disable iff (rst_i)
    (reset_kind_i == RST_PIN_SLEEP) |=> st_r.status[7:3] == 5'b00010)
    else $error("pin reset in sleep status wrong");
  a_vector_on_take: assert property (@(posedge core_clk_i)
    disable iff (rst_i)
    (st_r.seq == SEQ_VECTOR && reset_kind_i == RST_NONE) |=>
      stack_push_o && pc_value_o == `IRQ_VECTOR &&
      !st_r.irq_control_register[`IC_GIE])
    else $error("vectoring incomplete");
  a_dir_reset_ones: assert property (@(posedge core_clk_i)
    disable iff (rst_i)
    (reset_kind_i != RST_NONE) |=> port_a_direction_o == 6'h3F)
    else $error("port A not inputs after reset");
  a_gie_reset_clear: assert property (@(posedge core_clk_i)
    disable iff (rst_i)
    (reset_kind_i != RST_NONE) |=> !st_r.irq_control_register[`IC_GIE])
    else $error("global enable survived reset");
  a_flag_set_wins: assert property (@(posedge core_clk_i)
    disable iff (rst_i)
    (ext_edge && reset_kind_i == RST_NONE) |=>
      st_r.irq_control_register[`IC_EXTIF])
    else $error("edge flag lost");
  a_take_latency: assert property (@(posedge core_clk_i)
    disable iff (rst_i)
    (st_r.seq == SEQ_RUN && $past(st_r.seq) == SEQ_RUN &&
     st_r.irq_control_register[`IC_GIE] && pending &&
     !core_ctl_i.return_from_irq_instr && reset_kind_i == RST_NONE) |=>
      st_r.seq == SEQ_WAIT ##1 st_r.seq == SEQ_WAIT ##1
      st_r.seq == SEQ_VECTOR ##1 (pc_load_o && stack_push_o))
    else $error("interrupt latency wrong");
  a_no_take_no_gie: assert property (@(posedge core_clk_i)
    disable iff (rst_i)
    (st_r.seq == SEQ_RUN && !st_r.irq_control_register[`IC_GIE]) |=>
      st_r.seq != SEQ_WAIT)
    else $error("interrupt taken while globally disabled");
  a_unused_zero: assert property (@(posedge core_clk_i)
    disable iff (rst_i)
    ($past(reg_re_i) && $past(reg_addr_i) == `OFS_POWER_CONTROL) |->
      reg_rdata_o[7:2] == 6'h00)
    else $error("unimplemented bits not zero");
  a_return_from_irq_instr_rearm: assert property (@(posedge core_clk_i)
    disable iff (rst_i)
    (st_r.seq == SEQ_RUN && core_ctl_i.return_from_irq_instr &&
     reset_kind_i == RST_NONE) |=> st_r.irq_control_register[`IC_GIE])
    else $error("return did not re-arm");

  // ****************************************************************
  // Wake-up and flag checks
  // ****************************************************************
  a_wake_resume_next: assert property (@(posedge core_clk_i)
    disable iff (rst_i)
    (st_r.seq == SEQ_SLEEP && !watchdog_wake_i && pending &&
     reset_kind_i == RST_NONE) |=>
      pc_load_o && pc_value_o == PC_W'($past(pc_i) + 1'b1) &&
      st_r.status[4:3] == 2'b10)
    else $error("interrupt wake resumed wrongly");
  a_wake_to_vector: assert property (@(posedge core_clk_i)
    disable iff (rst_i)
    (st_r.seq == SEQ_SLEEP && !watchdog_wake_i && pending &&
     st_r.irq_control_register[`IC_GIE] && reset_kind_i == RST_NONE) |=>
      st_r.seq == SEQ_VECTOR ##1
      (stack_push_o && pc_value_o == `IRQ_VECTOR))
    else $error("wake with global enable missed the vector");
  a_por_status_ones: assert property (@(posedge core_clk_i)
    disable iff (rst_i)
    (reset_kind_i == RST_POWER_ON) |=> st_r.status[4:3] == 2'b11)
    else $error("power-on status flags not both one");
  a_periph_flag_set: assert property (@(posedge core_clk_i)
    disable iff (rst_i)
    (reset_kind_i == RST_NONE) |=>
      (st_r.periph_flags_first & $past(pf1_set)) == $past(pf1_set))
    else $error("peripheral flag not set by its event");
  a_flag_write_clear: assert property (@(posedge core_clk_i)
    disable iff (rst_i)
    (reg_we_i && reg_addr_i == `OFS_PERIPH_FLAGS_FIRST &&
     reg_wdata_i == 8'h00 && pf1_set == 8'h00 &&
     reset_kind_i == RST_NONE) |=> st_r.periph_flags_first == 8'h00)
    else $error("written zero did not clear the flags");

endmodule

// >>> logic/irq_reset_map.svh
// Offsets, field positions, reset values and timing counts for the
// reset-state and interrupt vectoring block.
// Assumes an 8-bit register port with one-cycle read latency.
`ifndef IRQ_RESET_MAP_SVH
`define IRQ_RESET_MAP_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFS_STATUS 4'h3
`define OFS_IRQ_CONTROL 4'hB
`define OFS_PERIPH_FLAGS_FIRST 4'hC
`define OFS_PERIPH_FLAGS_SECOND 4'hD
`define OFS_POWER_CONTROL 4'hE
`define OFS_PERIPH_EN_FIRST 4'h8
`define OFS_PERIPH_EN_SECOND 4'h9
`define OFS_PORT_A_DIRECTION 4'h5

// ****************************************************************
// Field positions
// ****************************************************************
`define IC_GIE 7
`define IC_PEIE 6
`define IC_T0IE 5
`define IC_EXTIE 4
`define IC_RBIE 3
`define IC_T0IF 2
`define IC_EXTIF 1
`define IC_RBIF 0
`define ST_TO 4
`define ST_PD 3
`define PC_POR 1
`define PC_BOR 0

// ****************************************************************
// Reset values and vectors
// ****************************************************************
`define RESET_VECTOR 13'h0000
`define IRQ_VECTOR 13'h0004
`define PORT_A_DIR_RESET 6'h3F
`define PERIPH_FIRST_MASK 8'h3F
`define PERIPH_SECOND_MASK 8'h0F
`define POWER_CONTROL_STATUS_MASK 8'h03

// ****************************************************************
// Timing: external event to vector, in core cycles
// ****************************************************************
`define EXT_LATENCY_CYCLES 3

`endif

// >>> logic/irq_reset_pkg.sv
// Types shared by the reset-state and interrupt vectoring block.
// Assumes irq_reset_map.svh is on the include path.
package irq_reset_pkg;

  typedef enum logic [2:0] {
    RST_NONE = 3'b000,
    RST_POWER_ON = 3'b001,
    RST_BROWNOUT = 3'b010,
    RST_PIN_RUN = 3'b011,
    RST_PIN_SLEEP = 3'b100,
    RST_WATCHDOG = 3'b101
  } reset_kind_e;

  typedef enum logic [1:0] {
    SEQ_RUN = 2'b00,
    SEQ_SLEEP = 2'b01,
    SEQ_WAIT = 2'b10,
    SEQ_VECTOR = 2'b11
  } seq_state_e;

  typedef struct packed {
    logic sleep;
    logic return_from_irq_instr;
    logic instr_done;
  } core_ctl_s;

  typedef struct packed {
    logic timer_zero_ovf;
    logic port_b_change;
    logic [7:0] periph_first;
    logic [7:0] periph_second;
  } irq_events_s;

endpackage
